/* logic/osc_consts.vh */
`ifndef OSC_CONSTS_VH
`define OSC_CONSTS_VH
// Register byte addresses on the APB.
`define OSC_ADDR_CTRL      12'h000
`define OSC_ADDR_STATUS    12'h004
`define OSC_ADDR_IRQ_STAT  12'h008
`define OSC_ADDR_IRQ_EN    12'h00c
`define OSC_ADDR_IRQ_CLR   12'h010
// Control register fields and reset value.
`define OSC_BIT_INT_EN     7
`define OSC_BIT_XTL_EN     6
`define OSC_BIT_WDT_EN     5
`define OSC_BIT_PFAIL_EN   4
`define OSC_BIT_WFAIL_EN   3
`define OSC_SEL_MSB        2
`define OSC_CTRL_RESET     8'ha0
// Unlock values.
`define OSC_UNLOCK_1       8'he7
`define OSC_UNLOCK_2       8'h18
// Clock select codes.
`define OSC_SEL_IPO_FAST   3'h0
`define OSC_SEL_IPO_SLOW   3'h1
`define OSC_SEL_XTAL       3'h2
`define OSC_SEL_WDOG       3'h3
`define OSC_SEL_EXT_PIN    3'h4
// Interrupt status bits.
`define OSC_IRQ_PFAIL      0
`define OSC_IRQ_WFAIL      1
`define OSC_IRQ_BAD_SEQ    2
`define OSC_IRQ_UPDATED    3
`define OSC_IRQ_W          4
// Watchdog oscillator failure window in system clocks.
`define OSC_WFAIL_CYCLES   8004
`endif

/* logic/osc_sync2.v */
`timescale 1ns/100ps
// Two-flop synchroniser for one pin level.
module osc_sync2 (
    input  wire pclk,
    input  wire presetn,
    input  wire d,
    output reg  q
);
    reg meta_q;

    // First flop feeds only the second one.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_q <= 1'b0;
            q      <= 1'b0;
        end else begin
            meta_q <= d;
            q      <= meta_q;
        end
    end
endmodule

/* logic/osc_unlock_fsm.v */
`timescale 1ns/100ps
`include "osc_consts.vh"
// Unlock sequencer for the oscillator control register.
module osc_unlock_fsm (
    input  wire       pclk,
    input  wire       presetn,
    input  wire       wr_ctrl,
    input  wire [7:0] wdata,
    output wire       commit,
    output wire       bad_seq,
    output wire [1:0] lock_state
);
    localparam [2:0] ST_LOCKED = 3'h1;
    localparam [2:0] ST_HALF   = 3'h2;
    localparam [2:0] ST_OPEN   = 3'h4;

    reg [2:0] state_q;
    reg [2:0] state_d;

    // Commit only the write that follows a full unlock pair.
    assign commit  = wr_ctrl && (state_q == ST_OPEN);
    // A write that breaks the pair is discarded and flagged.
    assign bad_seq = wr_ctrl && (((state_q == ST_LOCKED) && (wdata != `OSC_UNLOCK_1))
                   || ((state_q == ST_HALF) && (wdata != `OSC_UNLOCK_2)));
    assign lock_state = (state_q == ST_OPEN) ? 2'h2 : ((state_q == ST_HALF) ? 2'h1 : 2'h0);

    // Only writes to this register move the machine, so other traffic in between is harmless.
    always @* begin
        state_d = state_q;
        if (wr_ctrl) begin
            case (state_q)
                ST_LOCKED: state_d = (wdata == `OSC_UNLOCK_1) ? ST_HALF : ST_LOCKED; // see RL1
                ST_HALF:   state_d = (wdata == `OSC_UNLOCK_2) ? ST_OPEN : ST_LOCKED; // see RL4
                ST_OPEN:   state_d = ST_LOCKED; // see RL2
                default:   state_d = ST_LOCKED;
            endcase
        end
    end

    // Reset always lands in the locked state.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= ST_LOCKED; // see RL17
        end else begin
            state_q <= state_d;
        end
    end
endmodule

/* logic/osc_select_unlock_ctrl.v */
// Behaviour
// RL1: The control register unlocks only after 0xe7 then 0x18 are written to it.
// RL2: The write after the unlock pair becomes the register value and relocks it.
// RL3: Any other write sequence leaves the stored value unchanged.
// RL4: The two unlock values must be ordered but need not be on consecutive bus cycles.
// RL5: Accesses to other registers in between do not disturb the unlock progress.
// RL6: Software disables both failure detections before switching the clock source.
// RL7: A failure seen during a switch with detection enabled may raise a failure interrupt.
// RL8: Failure detection may be enabled again any time after a committed select write.
// RL9: After reset the internal precision oscillator is enabled.
// RL10: Changing the clock source never clears the internal oscillator enable by itself.
// RL11: Crystal use needs option mode set, unlock, enable, wait for stability, then select.
// RL12: External RC needs option mode, unlock, crystal circuit enable, then select.
// RL13: External clock needs its port pin configured, then unlock and select.
// RL14: Watchdog oscillator must be running before it is unlocked and selected.
// RL15: The select field maps 000 fast INTERNAL_PRECISION_OSC, 001 slow INTERNAL_PRECISION_OSC, 010 crystal, 011 watchdog, 100 pin.
// RL16: The primary failure enable turns on both detection and recovery together.
// RL17: Reset starts locked, and reads return the stored value in every lock state.
//
// Decided for this implementation: the register addresses and the APB interface to the registers.
`timescale 1ns/100ps
`include "osc_consts.vh"
module osc_select_unlock_ctrl (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire        primary_osc_fail,
    input  wire        wdog_osc_tick,
    output reg  [7:0]  osc_control_reg,
    output reg  [2:0]  sys_clock_select,
    output reg         internal_osc_en,
    output reg         crystal_osc_en,
    output reg         wdog_osc_en,
    output reg         irq
);
    reg  [`OSC_IRQ_W-1:0] irq_stat_q;
    reg  [`OSC_IRQ_W-1:0] irq_en_q;
    reg  [`OSC_IRQ_W-1:0] irq_set;
    reg  [`OSC_IRQ_W-1:0] irq_clr;
    reg  [13:0]           wfail_cnt_q;
    reg                   tick_d1_q;
    reg                   recovered_q;
    reg  [31:0]           rdata_d;
    reg                   addr_ok;
    wire                  pfail_s;
    wire                  wtick_s;
    wire                  wr_ctrl;
    wire                  commit;
    wire                  bad_seq;
    wire [1:0]            lock_state;
    wire                  access;
    wire                  wtick_edge;
    wire                  pfail_en;
    wire                  wfail_en;
    wire                  wfail_hit;
    wire [2:0]            sel_field;

    // Failure and tick pins come from other oscillators, so both are synchronised.
    osc_sync2 u_sync_pfail (
        .pclk    (pclk),
        .presetn (presetn),
        .d       (primary_osc_fail),
        .q       (pfail_s)
    );
    osc_sync2 u_sync_wtick (
        .pclk    (pclk),
        .presetn (presetn),
        .d       (wdog_osc_tick),
        .q       (wtick_s)
    );

    // Access phase of an APB transfer; every access takes one wait state before pready.
    assign access  = psel && penable && !pready;
    assign wr_ctrl = access && pwrite && (paddr == `OSC_ADDR_CTRL);

    // The sequencer only sees control register writes.
    osc_unlock_fsm u_unlock (
        .pclk       (pclk),
        .presetn    (presetn),
        .wr_ctrl    (wr_ctrl), // see RL5
        .wdata      (pwdata[7:0]),
        .commit     (commit),
        .bad_seq    (bad_seq),
        .lock_state (lock_state)
    );

    assign pfail_en  = osc_control_reg[`OSC_BIT_PFAIL_EN];
    assign wfail_en  = osc_control_reg[`OSC_BIT_WFAIL_EN];
    assign sel_field = osc_control_reg[`OSC_SEL_MSB:0];
    assign wtick_edge = wtick_s && !tick_d1_q;
    assign wfail_hit = (wfail_cnt_q == 14'd`OSC_WFAIL_CYCLES);

    // Address decode and read mux; unmapped addresses answer with an error.
    always @* begin
        rdata_d = 32'h0000_0000;
        addr_ok = 1'b1;
        case (paddr)
            `OSC_ADDR_CTRL:     rdata_d = {24'h00_0000, osc_control_reg}; // see RL17
            `OSC_ADDR_STATUS:   rdata_d = {27'h000_0000, recovered_q, sys_clock_select,
                                           1'b0} | {30'h0000_0000, lock_state};
            `OSC_ADDR_IRQ_STAT: rdata_d = {28'h000_0000, irq_stat_q};
            `OSC_ADDR_IRQ_EN:   rdata_d = {28'h000_0000, irq_en_q};
            `OSC_ADDR_IRQ_CLR:  rdata_d = 32'h0000_0000;
            default:            addr_ok = 1'b0;
        endcase
    end

    // APB answer: pready pulses for one cycle in the access phase.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= access;
            pslverr <= access && !addr_ok;
            if (access && !pwrite) begin
                prdata <= rdata_d;
            end
        end
    end

    // Control register only changes on a committed write after the pair.
    // A committed write loads the enables together with select, so software must write them
    // set to keep its oscillators running.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            osc_control_reg <= `OSC_CTRL_RESET; // see RL9
        end else if (commit) begin
            osc_control_reg <= pwdata[7:0]; // see RL2
        end // see RL3
    end // see RL10

    // Select decode; a reserved code keeps the last legal source.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sys_clock_select <= `OSC_SEL_IPO_FAST;
            internal_osc_en  <= 1'b1; // see RL9
            crystal_osc_en   <= 1'b0;
            wdog_osc_en      <= 1'b1;
            recovered_q      <= 1'b0;
        end else begin
            internal_osc_en <= osc_control_reg[`OSC_BIT_INT_EN]; // see RL10
            crystal_osc_en  <= osc_control_reg[`OSC_BIT_XTL_EN];
            wdog_osc_en     <= osc_control_reg[`OSC_BIT_WDT_EN];
            if (commit) begin
                recovered_q <= 1'b0;
            end else if (pfail_s && pfail_en && wdog_osc_en
                         && (sys_clock_select != `OSC_SEL_WDOG)) begin
                recovered_q <= 1'b1; // see RL16
            end
            if (recovered_q) begin
                sys_clock_select <= `OSC_SEL_WDOG; // see RL16
            end else if (sel_field <= `OSC_SEL_EXT_PIN) begin
                sys_clock_select <= sel_field; // see RL15
            end
        end
    end

    // Watchdog oscillator watcher counts system clocks between its ticks.
    // It cannot work while that oscillator is the system clock; a stopped one is caught after the window.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_d1_q   <= 1'b0;
            wfail_cnt_q <= 14'h0000;
        end else begin
            tick_d1_q <= wtick_s;
            if (wtick_edge || !wfail_en || wfail_hit || commit) begin
                wfail_cnt_q <= 14'h0000; // see RL8
            end else begin
                wfail_cnt_q <= wfail_cnt_q + 14'h0001;
            end
        end
    end

    // Sticky events; a set in the clearing cycle wins.
    always @* begin
        irq_set = {`OSC_IRQ_W{1'b0}};
        irq_set[`OSC_IRQ_PFAIL]   = pfail_s && pfail_en; // see RL7
        irq_set[`OSC_IRQ_WFAIL]   = wfail_hit && wfail_en; // see RL7
        irq_set[`OSC_IRQ_BAD_SEQ] = bad_seq; // see RL3
        irq_set[`OSC_IRQ_UPDATED] = commit; // see RL8
        irq_clr = (access && pwrite && (paddr == `OSC_ADDR_IRQ_CLR)) ?
                  pwdata[`OSC_IRQ_W-1:0] : {`OSC_IRQ_W{1'b0}};
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat_q <= {`OSC_IRQ_W{1'b0}};
            irq_en_q   <= {`OSC_IRQ_W{1'b0}};
            irq        <= 1'b0;
        end else begin
            irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
            if (access && pwrite && (paddr == `OSC_ADDR_IRQ_EN)) begin
                irq_en_q <= pwdata[`OSC_IRQ_W-1:0];
            end
            irq <= |(irq_stat_q & irq_en_q);
        end
    end
endmodule

/* bench/osc_chk_asserts.sv */
`timescale 1ns/100ps
// Port checker for the oscillator select block.
module osc_chk (
    input wire        pclk,
    input wire        presetn,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire        pready,
    input wire        pslverr,
    input wire [7:0]  osc_control_reg,
    input wire [2:0]  sys_clock_select,
    input wire        internal_osc_en,
    input wire        crystal_osc_en,
    input wire        wdog_osc_en
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_ctrl_from_write: assert property (
        $changed(osc_control_reg) |-> $past(psel && pwrite && paddr == 12'h000, 2) &&
        ($past(pwdata[7:0]) == osc_control_reg || $past(pwdata[7:0], 2) == osc_control_reg))
        else $error("control value changed without a control write");
    a_en_copies: assert property (
        {internal_osc_en, crystal_osc_en, wdog_osc_en} == $past(osc_control_reg[7:5]))
        else $error("enable outputs do not follow the control value");
    a_sel_legal: assert property (
        $changed(sys_clock_select) |-> sys_clock_select <= 3'h4 &&
        (sys_clock_select == 3'h3 || $past(osc_control_reg[2:0]) == sys_clock_select))
        else $error("clock select took an unexpected code");
    a_read_ctrl: assert property (
        pready && psel && !pwrite && paddr == 12'h000 |-> prdata == {24'h0, osc_control_reg})
        else $error("control read differs from stored value");
    a_err_unmapped: assert property (
        pready |-> pslverr == !(paddr == 12'h000 || paddr == 12'h004 || paddr == 12'h008
        || paddr == 12'h00c || paddr == 12'h010))
        else $error("error response wrong for address");
    a_ready_wait: assert property (
        psel && penable && !pready |=> pready)
        else $error("no answer one cycle into access");
    a_ready_pulse: assert property (
        pready |=> !pready)
        else $error("ready held longer than one cycle");
    a_sel_idle: assert property (
        !psel [*4] |=> $stable(sys_clock_select) || sys_clock_select == 3'h3)
        else $error("clock select moved with the bus idle");
endmodule

bind osc_select_unlock_ctrl osc_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .osc_control_reg, .sys_clock_select,
    .internal_osc_en, .crystal_osc_en, .wdog_osc_en);

/* bench/osc_src_model.sv */
`timescale 1ns/100ps
// Oscillator sources seen by the block.
module osc_src_model (
    input  wire pclk,
    input  wire wdog_osc_en,
    input  wire fail_cmd,
    output reg  wdog_osc_tick,
    output wire primary_osc_fail
);
    reg [1:0] div_q = 2'h0;
    initial wdog_osc_tick = 1'b0;
    // A disabled watchdog oscillator stops ticking, so its failure can be seen.
    always @(posedge pclk) begin
        div_q <= div_q + 2'h1;
        if (wdog_osc_en && div_q == 2'h3) begin
            wdog_osc_tick <= ~wdog_osc_tick;
        end
    end
    // The primary oscillator fails only when the bench commands it.
    assign primary_osc_fail = fail_cmd;
endmodule

/* bench/tb.sv */
`timescale 1ns/100ps
`include "osc_consts.vh"
module tb;
    reg         pclk, presetn, psel, penable, pwrite, fail_cmd, err;
    reg  [11:0] paddr;
    reg  [31:0] pwdata, rd;
    wire [31:0] prdata;
    wire        pready, pslverr, tick, pfail, irq, ien, xen, wen;
    wire [7:0]  ctl;
    wire [2:0]  sel;
    integer     n_mismatch, n_tests, i;
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    osc_select_unlock_ctrl dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .primary_osc_fail(pfail), .wdog_osc_tick(tick),
        .osc_control_reg(ctl), .sys_clock_select(sel), .internal_osc_en(ien),
        .crystal_osc_en(xen), .wdog_osc_en(wen), .irq);
    osc_src_model u_src (.pclk, .wdog_osc_en(wen), .fail_cmd, .wdog_osc_tick(tick),
        .primary_osc_fail(pfail));
    task end_of_test;
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task chk(input [31:0] got, input [31:0] exp);
        n_tests = n_tests + 1;
        if (got !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // One APB transfer; the request is held until ready is seen, then an idle edge.
    task apb(input w, input [11:0] a, input [31:0] d);
        integer k;
        k = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && k < 20) begin
            @(posedge pclk);
            k = k + 1;
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            n_mismatch = n_mismatch + 1;
            end_of_test;
        end
        @(posedge pclk);
    endtask
    task wr(input [11:0] a, input [7:0] d);
        apb(1'b1, a, {24'h0, d});
    endtask
    task rdchk(input [11:0] a, input [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd, e);
    endtask
    // Full unlock pair and commit, then let the enables and select settle.
    task unl(input [7:0] d);
        wr(`OSC_ADDR_CTRL, `OSC_UNLOCK_1);
        wr(`OSC_ADDR_CTRL, `OSC_UNLOCK_2);
        wr(`OSC_ADDR_CTRL, d);
        repeat (3) @(posedge pclk);
    endtask
    task t_reset;
        rdchk(`OSC_ADDR_CTRL, 32'ha0);
        chk(ien, 1);
    endtask
    // Wrong orders never unlock; the bad sequence event drives the interrupt.
    task t_lock;
        wr(`OSC_ADDR_CTRL, 8'h00);
        wr(`OSC_ADDR_CTRL, 8'h18);
        wr(`OSC_ADDR_CTRL, 8'he7);
        wr(`OSC_ADDR_CTRL, 8'he7);
        wr(`OSC_ADDR_CTRL, 8'h00);
        rdchk(`OSC_ADDR_CTRL, 32'ha0);
        chk(irq, 0);
        wr(`OSC_ADDR_IRQ_EN, 8'h04);
        chk(irq, 1);
        rdchk(`OSC_ADDR_IRQ_STAT, 32'h4);
        wr(`OSC_ADDR_IRQ_CLR, 8'h04);
        chk(irq, 0);
    endtask
    // Other registers touched between the unlock steps; commit relocks.
    task t_gap;
        wr(`OSC_ADDR_CTRL, `OSC_UNLOCK_1);
        rdchk(`OSC_ADDR_IRQ_EN, 32'h4);
        rdchk(`OSC_ADDR_STATUS, 32'h1);
        wr(`OSC_ADDR_IRQ_EN, 8'h04);
        wr(`OSC_ADDR_CTRL, `OSC_UNLOCK_2);
        rdchk(`OSC_ADDR_STATUS, 32'h2);
        // The pair is already complete, so this single write is the commit.
        wr(`OSC_ADDR_CTRL, 8'he2);
        repeat (3) @(posedge pclk);
        rdchk(`OSC_ADDR_CTRL, 32'he2);
        chk({ien, xen, sel}, 5'h1a);
        wr(`OSC_ADDR_CTRL, 8'h00);
        rdchk(`OSC_ADDR_CTRL, 32'he2);
    endtask
    // Every legal select code, then reserved code 5 last; then an explicit oscillator clear.
    task t_codes;
        for (i = 0; i < 6; i = i + 1) begin
            unl(8'ha0 | i[7:0]);
            chk(sel, (i < 5) ? i : 4);
            chk(ien, 1);
        end
        unl(8'h23);
        chk({ien, sel}, 4'h3);
        apb(1'b1, 12'h100, 32'hff);
        chk(err, 1);
        apb(1'b0, 12'h100, 32'h0);
        chk({err, rd}, {1'b1, 32'h0});
    endtask
    // Primary failure with recovery enabled forces the watchdog source.
    task t_recover;
        wr(`OSC_ADDR_IRQ_CLR, 8'h0f);
        unl(8'h30);
        chk(sel, 0);
        fail_cmd <= 1'b1;
        repeat (8) @(posedge pclk);
        chk(sel, 3);
        rdchk(`OSC_ADDR_STATUS, 32'h16);
        rdchk(`OSC_ADDR_IRQ_STAT, 32'h9);
        fail_cmd <= 1'b0;
    endtask
    // Watchdog oscillator stopped with its detection on: no event early, one after the window.
    task t_wfail;
        unl(8'h88);
        wr(`OSC_ADDR_IRQ_CLR, 8'h0f);
        repeat (7900) @(posedge pclk);
        rdchk(`OSC_ADDR_IRQ_STAT, 32'h0);
        repeat (200) @(posedge pclk);
        rdchk(`OSC_ADDR_IRQ_STAT, 32'h2);
    endtask
    initial begin
        n_mismatch = 0;
        n_tests = 0;
        {presetn, psel, penable, pwrite, fail_cmd, err} = 6'h0;
        paddr = 12'h0;
        pwdata = 32'h0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset;
        t_lock;
        t_gap;
        t_codes;
        t_recover;
        t_wfail;
        end_of_test;
    end
endmodule
